/* File: rtl/gtc_timer.sv */
// Gated 16-bit timer: clock select, prescaler, gate logic, wide access, event clear.
`timescale 1ns/10ps
`default_nettype none
`include "gtc_map.svh"
module gtc_timer
    import gtc_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic                   clock_in,
    input  wire logic                   nrst_in,
    // Register port.
    input  wire logic [`GTC_ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [7:0]             reg_rdata_out,
    // Clock and gate sources from outside.
    input  wire logic                   pin_clock_in,
    input  wire logic [16:3]            ext_clock_in,
    input  wire logic                   gate_in,
    // Capture/compare side.
    input  wire logic                   special_event_in,
    output logic      [15:0]            timer_count_out,
    // Status.
    output logic                        rollover_flag_out,
    output logic                        gate_event_flag_out,
    output logic                        gate_level_out
);
    gtc_byte_t   con_reg;
    logic [3:0]  gctl_reg;
    logic        go_reg;
    logic        go_next;
    logic [4:0]  cs_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    gtc_byte_t   hbuf_reg;
    gtc_byte_t   hbuf_next;
    logic        roll_reg;
    logic        gevt_reg;
    gtc_byte_t   rdata_reg;
    gtc_byte_t   rdata_next;
    logic [1:0]  inst_cnt_reg;
    logic        src_prev_reg;
    logic        g_prev_reg;
    logic        toggle_reg;
    logic        gt_prev_reg;
    logic        gl_prev_reg;
    gtc_pulse_e  sp_state_reg;
    gtc_pulse_e  sp_state_next;

    // Field views.
    logic        on_bit;
    logic        wide_access_enable_bit;
    logic        sync_bit;
    logic [1:0]  prescale_select;
    logic        ge_bit;
    logic        gate_polarity_bit;
    logic        gtm_bit;
    logic        gate_single_pulse_mode_bit;
    assign on_bit   = con_reg[`GTC_CON_ON];
    assign wide_access_enable_bit = con_reg[`GTC_CON_WIDE_ACCESS_ENABLE];
    assign sync_bit = con_reg[`GTC_CON_SYNC];
    assign prescale_select     = con_reg[`GTC_CON_PRESCALE_SELECT+1:`GTC_CON_PRESCALE_SELECT];
    assign ge_bit   = gctl_reg[3];
    assign gate_polarity_bit = gctl_reg[2];
    assign gtm_bit  = gctl_reg[1];
    assign gate_single_pulse_mode_bit = gctl_reg[0];

    // Address decode.
    logic wr_lo;
    logic wr_hi;
    logic wr_con;
    logic wr_gcon;
    logic wr_clk;
    logic wr_stat;
    logic rd_lo;
    logic cnt_wr;
    assign wr_lo   = reg_wr_in && (reg_addr_in == `GTC_OFS_COUNT_LO);
    assign wr_hi   = reg_wr_in && (reg_addr_in == `GTC_OFS_COUNT_HI);
    assign wr_con  = reg_wr_in && (reg_addr_in == `GTC_OFS_CON);
    assign wr_gcon = reg_wr_in && (reg_addr_in == `GTC_OFS_GCON);
    assign wr_clk  = reg_wr_in && (reg_addr_in == `GTC_OFS_CLK);
    assign wr_stat = reg_wr_in && (reg_addr_in == `GTC_OFS_STATUS);
    assign rd_lo   = reg_rd_in && (reg_addr_in == `GTC_OFS_COUNT_LO);
    assign cnt_wr  = wr_lo || wr_hi;

    // Input synchronisers: bit 0 pin clock, bit 1 gate, bits 15:2 other sources.
    logic [15:0] sy_filt;
    logic [15:0] sy_fast;
    gtc_sync #(
        .WIDTH   (16)
    ) u_sync (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .async_in ({ext_clock_in, gate_in, pin_clock_in}),
        .filt_out (sy_filt),
        .fast_out (sy_fast)
    );

    // Clock source selection and edge detection.
    logic        src_direct;
    logic        unsync;
    logic [15:0] src_lvls;
    logic        src_level;
    logic        inst_tick;
    logic        src_tick;
    logic        in_ext_range;
    assign inst_tick    = (inst_cnt_reg == `GTC_INST_LAST);
    assign src_direct   = (cs_reg == `GTC_CS_INST) || (cs_reg == `GTC_CS_FOSC);
    assign unsync       = !src_direct && sync_bit;
    assign src_lvls     = unsync ? sy_fast : sy_filt;
    assign in_ext_range = (cs_reg >= `GTC_CS_EXT_LO) && (cs_reg <= `GTC_CS_EXT_HI);
    assign src_level    = (cs_reg == `GTC_CS_PIN) ? src_lvls[0] :
                          in_ext_range ? src_lvls[4'(cs_reg - 5'd1)] : 1'b0;
    assign src_tick     = (cs_reg == `GTC_CS_INST) ? inst_tick :
                          (cs_reg == `GTC_CS_FOSC) ? 1'b1 :
                          (src_level && !src_prev_reg);

    // Prescaler, cleared by a low-byte write.
    logic pre_pulse;
    gtc_prescale #(
        .WIDTH     (3)
    ) u_pre (
        .clock_in  (clock_in),
        .nrst_in   (nrst_in),
        .tick_in   (src_tick),
        .clear_in  (wr_lo),
        .sel_in    (prescale_select),
        .pulse_out (pre_pulse)
    );

    // Gate path: polarity, toggle, single pulse.
    logic g_pol;
    logic gate_t;
    logic gt_rise;
    logic gt_fall;
    logic gate_level;
    assign g_pol      = gate_polarity_bit ? sy_filt[1] : !sy_filt[1];
    assign gate_t     = gtm_bit ? toggle_reg : g_pol;
    assign gt_rise    = gate_t && !gt_prev_reg;
    assign gt_fall    = !gate_t && gt_prev_reg;
    assign gate_level = gate_single_pulse_mode_bit ? (sp_state_reg == GTC_SP_OPEN) && gate_t
                                 : gate_t;

    always_comb begin
        sp_state_next = sp_state_reg;
        case (sp_state_reg)
            GTC_SP_IDLE: begin
                if (gate_single_pulse_mode_bit && go_reg) begin
                    sp_state_next = GTC_SP_ARMED;
                end
            end
            GTC_SP_ARMED: begin
                if (!gate_single_pulse_mode_bit || !go_reg) begin
                    sp_state_next = GTC_SP_IDLE;
                end else if (gt_rise) begin
                    sp_state_next = GTC_SP_OPEN;
                end
            end
            GTC_SP_OPEN: begin
                if (!gate_single_pulse_mode_bit || gt_fall) begin
                    sp_state_next = GTC_SP_IDLE;
                end
            end
            default: begin
                sp_state_next = GTC_SP_IDLE;
            end
        endcase
    end

    // Go bit: software sets it, the trailing edge or leaving the mode clears it.
    logic gate_single_pulse_mode_next;
    assign gate_single_pulse_mode_next = wr_gcon ? reg_wdata_in[`GTC_GCON_GATE_SINGLE_PULSE_MODE] : gate_single_pulse_mode_bit;
    always_comb begin
        if (!gate_single_pulse_mode_next) begin
            go_next = 1'b0;
        end else if (wr_gcon) begin
            go_next = reg_wdata_in[`GTC_GCON_GO];
        end else if (sp_state_reg == GTC_SP_OPEN && gt_fall) begin
            go_next = 1'b0;
        end else begin
            go_next = go_reg;
        end
    end

    // Counting.
    logic cnt_run;
    logic inc;
    logic sevt_take;
    logic roll_set;
    logic gevt_set;
    assign cnt_run   = on_bit && (!ge_bit || gate_level);
    assign inc       = cnt_run && pre_pulse;
    assign sevt_take = special_event_in && !unsync;
    assign roll_set  = inc && !cnt_wr && !sevt_take && (count_reg == `GTC_COUNT_MAX);
    assign gevt_set  = gl_prev_reg && !gate_level;

    always_comb begin
        if (wr_lo) begin
            count_next = wide_access_enable_bit ? {hbuf_reg, reg_wdata_in}
                                  : {count_reg[15:8], reg_wdata_in};
        end else if (wr_hi) begin
            count_next = wide_access_enable_bit ? count_reg : {reg_wdata_in, count_reg[7:0]};
        end else if (sevt_take) begin
            count_next = `GTC_COUNT_RST;
        end else if (inc) begin
            count_next = 16'(count_reg + 16'h0001);
        end else begin
            count_next = count_reg;
        end
    end

    always_comb begin
        if (wide_access_enable_bit && wr_hi) begin
            hbuf_next = reg_wdata_in;
        end else if (rd_lo) begin
            hbuf_next = count_reg[15:8];
        end else begin
            hbuf_next = hbuf_reg;
        end
    end

    // Read data, presented in the cycle after the read strobe.
    always_comb begin
        case (reg_addr_in)
            `GTC_OFS_COUNT_LO: rdata_next = count_reg[7:0];
            `GTC_OFS_COUNT_HI: rdata_next = wide_access_enable_bit ? hbuf_reg : count_reg[15:8];
            `GTC_OFS_CON:      rdata_next = con_reg;
            `GTC_OFS_GCON:     rdata_next = {gctl_reg, go_reg, gate_level, 2'b00};
            `GTC_OFS_CLK:      rdata_next = {3'b000, cs_reg};
            `GTC_OFS_STATUS:   rdata_next = {6'b00_0000, gevt_reg, roll_reg};
            default:           rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            con_reg  <= `GTC_CON_RST;
            gctl_reg <= `GTC_GCTL_RST;
            cs_reg   <= `GTC_CS_RST;
        end else begin
            if (wr_con) begin
                con_reg <= reg_wdata_in & `GTC_CON_MASK;
            end
            if (wr_gcon) begin
                gctl_reg <= reg_wdata_in[7:4];
            end
            if (wr_clk) begin
                cs_reg <= reg_wdata_in[4:0];
            end
        end
    end

    // Flags: a hardware set wins over a write-one clear in the same cycle.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            roll_reg <= 1'b0;
            gevt_reg <= 1'b0;
        end else begin
            roll_reg <= roll_set || (roll_reg && !(wr_stat && reg_wdata_in[`GTC_STAT_ROLL]));
            gevt_reg <= gevt_set || (gevt_reg && !(wr_stat && reg_wdata_in[`GTC_STAT_GEVT]));
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_reg    <= `GTC_COUNT_RST;
            hbuf_reg     <= 8'h00;
            go_reg       <= 1'b0;
            sp_state_reg <= GTC_SP_IDLE;
            rdata_reg    <= 8'h00;
        end else begin
            count_reg    <= count_next;
            hbuf_reg     <= hbuf_next;
            go_reg       <= go_next;
            sp_state_reg <= sp_state_next;
            rdata_reg    <= reg_rd_in ? rdata_next : 8'h00;
        end
    end

    // Edge history and the toggle flip-flop.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            inst_cnt_reg <= 2'h0;
            src_prev_reg <= 1'b0;
            g_prev_reg   <= 1'b0;
            toggle_reg   <= 1'b0;
            gt_prev_reg  <= 1'b0;
            gl_prev_reg  <= 1'b0;
        end else begin
            inst_cnt_reg <= 2'(inst_cnt_reg + 2'h1);
            src_prev_reg <= src_level;
            g_prev_reg   <= g_pol;
            gt_prev_reg  <= gate_t;
            gl_prev_reg  <= gate_level;
            if (!gtm_bit) begin
                toggle_reg <= 1'b0;
            end else if (g_pol && !g_prev_reg) begin
                toggle_reg <= !toggle_reg;
            end
        end
    end

    assign reg_rdata_out       = rdata_reg;
    assign timer_count_out     = count_reg;
    assign rollover_flag_out   = roll_reg;
    assign gate_event_flag_out = gevt_reg;
    assign gate_level_out      = gate_level;

    chk_sevt_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
        sevt_take && !cnt_wr |=> count_reg == 16'h0000)
        else $error("Special event did not clear the count.");

    chk_roll_cause: assert property (@(posedge clock_in) disable iff (!nrst_in)
        $rose(roll_reg) |-> $past(inc) && !$past(sevt_take) && $past(count_reg) == 16'hFFFF)
        else $error("Rollover flag set without a wrap.");

    chk_unsync_miss: assert property (@(posedge clock_in) disable iff (!nrst_in)
        special_event_in && unsync && !cnt_wr && !inc |=> $stable(count_reg))
        else $error("Unsynchronised timer took a special event.");

    chk_write_wins: assert property (@(posedge clock_in) disable iff (!nrst_in)
        wr_lo && special_event_in |=> count_reg[7:0] == $past(reg_wdata_in))
        else $error("Special event beat a count write.");

    chk_off_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !on_bit && !cnt_wr && !sevt_take |=> $stable(count_reg))
        else $error("Timer moved while off.");

    chk_gate_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
        on_bit && ge_bit && !gate_level && !cnt_wr && !sevt_take |=> $stable(count_reg))
        else $error("Timer counted with the gate closed.");

    chk_go_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !gate_single_pulse_mode_bit && !wr_gcon |=> !go_reg)
        else $error("Go bit survived with single pulse off.");

    chk_toggle_held: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !gtm_bit ##1 !gtm_bit |-> !toggle_reg)
        else $error("Toggle flip-flop not held clear.");

    chk_gate_event: assert property (@(posedge clock_in) disable iff (!nrst_in)
        $fell(gate_level) |=> gevt_reg)
        else $error("Gate event flag missed a falling edge.");

    chk_wide_read: assert property (@(posedge clock_in) disable iff (!nrst_in)
        rd_lo && !(wide_access_enable_bit && wr_hi) |=> hbuf_reg == $past(count_reg[15:8]))
        else $error("Low read did not latch the high byte.");
endmodule
`default_nettype wire

/* File: rtl/gtc_map.svh */
// Register offsets, field positions, reset values and counts of the gated timer.
`ifndef GTC_MAP_SVH
`define GTC_MAP_SVH

`define GTC_ADDR_W        12
`define GTC_OFS_COUNT_LO  12'h028C
`define GTC_OFS_COUNT_HI  12'h028D
`define GTC_OFS_CON       12'h028E
`define GTC_OFS_GCON      12'h028F
`define GTC_OFS_CLK       12'h0291
`define GTC_OFS_STATUS    12'h0298

`define GTC_CON_ON        0
`define GTC_CON_WIDE_ACCESS_ENABLE      1
`define GTC_CON_SYNC      2
`define GTC_CON_PRESCALE_SELECT      4
`define GTC_CON_MASK      8'h37
`define GTC_CON_RST       8'h00

`define GTC_GCON_GE       7
`define GTC_GCON_GATE_POLARITY     6
`define GTC_GCON_GTM      5
`define GTC_GCON_GATE_SINGLE_PULSE_MODE     4
`define GTC_GCON_GO       3
`define GTC_GCON_GATE_LEVEL     2
`define GTC_GCTL_RST      4'h0

`define GTC_STAT_ROLL     0
`define GTC_STAT_GEVT     1

`define GTC_CS_RST        5'h00
`define GTC_CS_PIN        5'h00
`define GTC_CS_INST       5'h01
`define GTC_CS_FOSC       5'h02
`define GTC_CS_EXT_LO     5'h03
`define GTC_CS_EXT_HI     5'h10

`define GTC_COUNT_RST     16'h0000
`define GTC_COUNT_MAX     16'hFFFF
`define GTC_INST_LAST     2'h3

`endif

/* File: rtl/gtc_pkg.sv */
// Types shared by the gated timer files.
package gtc_pkg;
    typedef logic [7:0] gtc_byte_t;
    typedef enum logic [2:0] {
        GTC_SP_IDLE  = 3'b001,
        GTC_SP_ARMED = 3'b010,
        GTC_SP_OPEN  = 3'b100
    } gtc_pulse_e;
endpackage

/* File: rtl/gtc_sync.sv */
// Three-stage input synchroniser with an agreement filter.
`timescale 1ns/10ps
`default_nettype none
module gtc_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] filt_out,
    output logic      [WIDTH-1:0] fast_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] filt_reg;
    logic [WIDTH-1:0] filt_next;

    // A bit moves only once the second and third stages agree.
    assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
    assign filt_out  = filt_reg;
    assign fast_out  = s3_reg;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;
        end else begin
            s1_reg   <= async_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/gtc_prescale.sv */
// Power-of-two prescaler that passes one tick in 1, 2, 4 or 8.
`timescale 1ns/10ps
`default_nettype none
module gtc_prescale #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    // Ticks, clear and ratio select.
    input  wire logic             tick_in,
    input  wire logic             clear_in,
    input  wire logic [1:0]       sel_in,
    output logic                  pulse_out
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] mask;
    logic             full;

    assign mask      = WIDTH'((1 << sel_in) - 1);
    assign full      = (cnt_reg & mask) == mask;
    assign pulse_out = tick_in & full & ~clear_in;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_reg <= '0;
        end else if (clear_in) begin
            cnt_reg <= '0;
        end else if (tick_in) begin
            cnt_reg <= full ? '0 : WIDTH'(cnt_reg + 1'b1);
        end
    end
endmodule
`default_nettype wire

/* File: tb/gtc_partner.sv */
// Far-side model: compare unit special event plus clock and gate sources.
`timescale 1ns/10ps
`default_nettype none
module gtc_partner #(
    parameter logic [15:0] CMP = 16'h0010
) (
    // Clock and reset.
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // Bench controls.
    input  wire logic        cmp_en_in,
    input  wire logic        fire_in,
    input  wire logic        gate_lvl_in,
    // Timer side.
    input  wire logic [15:0] count_in,
    output logic             sev_out,
    output logic             gate_out,
    output logic             pin_clk_out,
    output logic [16:3]      ext_clk_out
);
    logic [2:0] div_reg;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end
    // Free-running clock sources with a period of eight system clocks; the gate follows the bench level.
    assign pin_clk_out = div_reg[2];
    assign ext_clk_out = {14{div_reg[2]}};
    assign gate_out    = gate_lvl_in;
    // A match on the compare value clears the timer, so it acts as the period.
    assign sev_out     = fire_in | (cmp_en_in & (count_in == CMP));
endmodule
`default_nettype wire

/* File: tb/gtc_timer_test.sv */
// Self-checking testbench of the gated timer.
`timescale 1ns/10ps
`default_nettype none
`include "gtc_map.svh"
module gtc_timer_test;
    logic        clock_in;
    logic        nrst_in;
    logic        wr;
    logic        rd;
    logic        cmp_en;
    logic        fire;
    logic        sev_arm;
    logic        gate;
    logic        sev;
    logic        pin_clk;
    logic        roll;
    logic        gevt;
    logic        glvl;
    logic        gsrc;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [16:3] ext_clk;
    logic [15:0] count;
    int          fails;
    int          compares;

    gtc_timer gtc_timer_inst (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .pin_clock_in(pin_clk), .ext_clock_in(ext_clk), .gate_in(gsrc),
        .special_event_in(sev), .timer_count_out(count), .rollover_flag_out(roll),
        .gate_event_flag_out(gevt), .gate_level_out(glvl));
    gtc_partner gtc_partner_inst (.clock_in(clock_in), .nrst_in(nrst_in), .cmp_en_in(cmp_en),
        .fire_in(fire), .gate_lvl_in(gate), .count_in(count), .sev_out(sev),
        .gate_out(gsrc), .pin_clk_out(pin_clk), .ext_clk_out(ext_clk));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr8(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        fire <= sev_arm;
        @(posedge clock_in);
        wr <= 1'b0;
        fire <= 1'b0;
    endtask
    task automatic rd8(input logic [11:0] a, output logic [7:0] d);
        @(posedge clock_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Counts the increments over sixteen system clocks.
    task automatic measure(input logic [7:0] cs, con, gcon, exp);
        wr8(`GTC_OFS_CLK, cs);
        wr8(`GTC_OFS_GCON, gcon);
        wr8(`GTC_OFS_CON, con);
        rd8(`GTC_OFS_COUNT_LO, d0);
        repeat (14) @(posedge clock_in);
        rd8(`GTC_OFS_COUNT_LO, d1);
        chk("count step", {8'h00, exp}, {8'h00, d1 - d0});
    endtask
    task automatic set_gate(input logic g);
        @(posedge clock_in);
        gate <= g;
        repeat (8) @(posedge clock_in);
        #1;
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        fails++;
        tally_and_finish();
    end
    initial begin
        nrst_in = 1'b0;
        {wr, rd, cmp_en, fire, sev_arm, gate} = 6'h00;
        addr = 12'h000;
        wdata = 8'h00;
        fails = 0;
        compares = 0;
        repeat (3) @(posedge clock_in);
        nrst_in <= 1'b1;
        rd8(`GTC_OFS_CLK, d0);
        chk("clock select reset", 16'h0000, {8'h00, d0});
        wr8(`GTC_OFS_CON, 8'hFF);
        rd8(`GTC_OFS_CON, d0);
        chk("control mask", 16'h0037, {8'h00, d0});
        wr8(`GTC_OFS_CLK, 8'hFF);
        rd8(`GTC_OFS_CLK, d0);
        chk("clock select mask", 16'h001F, {8'h00, d0});
        rd8(12'h0200, d0);
        chk("unmapped read", 16'h0000, {8'h00, d0});
        for (int ps = 0; ps < 4; ps++) begin
            measure(8'h02, {2'b00, 2'(ps), 4'h1}, 8'h00, 8'(8'h10 >> ps));
        end
        measure(8'h01, 8'h01, 8'h00, 8'h04);
        measure(8'h02, 8'h05, 8'h00, 8'h10);
        measure(8'h00, 8'h01, 8'h00, 8'h02);
        measure(8'h03, 8'h05, 8'h00, 8'h02);
        measure(8'h02, 8'h00, 8'h80, 8'h00);
        measure(8'h02, 8'h01, 8'hC0, 8'h00);
        set_gate(1'b1);
        measure(8'h02, 8'h01, 8'hC0, 8'h10);
        measure(8'h02, 8'h01, 8'h80, 8'h00);
        chk("gate level", 16'h0000, {15'h0000, glvl});
        measure(8'h02, 8'h01, 8'h40, 8'h10);
        chk("gate level", 16'h0001, {15'h0000, glvl});
        wr8(`GTC_OFS_STATUS, 8'h03);
        set_gate(1'b0);
        rd8(`GTC_OFS_STATUS, d0);
        chk("gate event", 16'h0001, {15'h0000, d0[1]});
        chk("gate event out", 16'h0001, {15'h0000, gevt});
        wr8(`GTC_OFS_GCON, 8'hE0);
        set_gate(1'b1);
        set_gate(1'b0);
        chk("toggle level", 16'h0001, {15'h0000, glvl});
        wr8(`GTC_OFS_GCON, 8'hC0);
        wr8(`GTC_OFS_GCON, 8'hE0);
        repeat (4) @(posedge clock_in);
        chk("toggle cleared", 16'h0000, {15'h0000, glvl});
        wr8(`GTC_OFS_GCON, 8'hD8);
        rd8(`GTC_OFS_GCON, d0);
        chk("go armed", 16'h0001, {15'h0000, d0[3]});
        set_gate(1'b1);
        chk("pulse open", 16'h0001, {15'h0000, glvl});
        set_gate(1'b0);
        rd8(`GTC_OFS_GCON, d0);
        chk("go done", 16'h0000, {15'h0000, d0[3]});
        set_gate(1'b1);
        chk("pulse closed", 16'h0000, {15'h0000, glvl});
        wr8(`GTC_OFS_GCON, 8'hC8);
        rd8(`GTC_OFS_GCON, d0);
        chk("go cleared", 16'h0000, {15'h0000, d0[3]});
        chk("normal gate", 16'h0001, {15'h0000, glvl});
        wr8(`GTC_OFS_CON, 8'h02);
        wr8(`GTC_OFS_COUNT_HI, 8'hAB);
        wr8(`GTC_OFS_COUNT_LO, 8'hCD);
        #1;
        chk("wide write", 16'hABCD, count);
        rd8(`GTC_OFS_COUNT_LO, d0);
        wr8(`GTC_OFS_CON, 8'h00);
        wr8(`GTC_OFS_COUNT_HI, 8'h77);
        wr8(`GTC_OFS_CON, 8'h02);
        rd8(`GTC_OFS_COUNT_HI, d0);
        chk("wide high read", 16'h00AB, {8'h00, d0});
        wr8(`GTC_OFS_CON, 8'h00);
        rd8(`GTC_OFS_COUNT_HI, d0);
        chk("byte high read", 16'h0077, {8'h00, d0});
        wr8(`GTC_OFS_CLK, 8'h01);
        sev_arm = 1'b1;
        wr8(`GTC_OFS_COUNT_LO, 8'h55);
        sev_arm = 1'b0;
        #1;
        chk("write beats event", 16'h7755, count);
        sev_arm = 1'b1;
        wr8(`GTC_OFS_COUNT_HI, 8'h66);
        sev_arm = 1'b0;
        #1;
        chk("high write beats event", 16'h6655, count);
        wr8(`GTC_OFS_CLK, 8'h03);
        wr8(`GTC_OFS_CON, 8'h04);
        @(posedge clock_in);
        fire <= 1'b1;
        @(posedge clock_in);
        fire <= 1'b0;
        #1;
        chk("event ignored", 16'h6655, count);
        wr8(`GTC_OFS_CLK, 8'h02);
        wr8(`GTC_OFS_COUNT_HI, 8'hFF);
        wr8(`GTC_OFS_COUNT_LO, 8'hF8);
        wr8(`GTC_OFS_STATUS, 8'h03);
        wr8(`GTC_OFS_CON, 8'h01);
        repeat (12) @(posedge clock_in);
        rd8(`GTC_OFS_STATUS, d0);
        chk("rollover", 16'h0001, {15'h0000, d0[0]});
        chk("rollover out", 16'h0001, {15'h0000, roll});
        wr8(`GTC_OFS_CON, 8'h00);
        wr8(`GTC_OFS_CLK, 8'h01);
        wr8(`GTC_OFS_COUNT_HI, 8'hFF);
        wr8(`GTC_OFS_COUNT_LO, 8'hFF);
        wr8(`GTC_OFS_STATUS, 8'h03);
        // A clear from the maximum count must not look like a wrap.
        @(posedge clock_in);
        fire <= 1'b1;
        @(posedge clock_in);
        fire <= 1'b0;
        #1;
        chk("event from max", 16'h0000, count);
        @(posedge clock_in);
        cmp_en <= 1'b1;
        wr8(`GTC_OFS_CON, 8'h01);
        for (int k = 0; k < 200 && sev !== 1'b1; k++) begin
            @(posedge clock_in);
            #1;
        end
        chk("event seen", 16'h0001, {15'h0000, sev});
        @(posedge clock_in);
        #1;
        chk("event clear", 16'h0000, count);
        rd8(`GTC_OFS_STATUS, d0);
        chk("no rollover", 16'h0000, {15'h0000, d0[0]});
        chk("no rollover out", 16'h0000, {15'h0000, roll});
        tally_and_finish();
    end
endmodule
`default_nettype wire
